// >>> design/psm_ctrl.sv
// Power saving mode controller: slow clock divider, wait, active halt and
// halt sequencing, wake source filtering and wake delay.
// Assumes the CPU core pulses the wait and halt instruction inputs for one
// cycle and follows the mask, push and resume pulses it is given.
//
// Functional notes
// - Slow mode: enable bit plus two-bit divider
// - Slow clock is master divided 2/4/8/16
// - Wait during slow mode keeps divided clock
// - Wait stops CPU, peripherals keep running
// - Wait entry forces interrupt mask to 10
// - Wait ends on interrupt or reset, vectoring
// - Push status, load priority before servicing
// - Halt picks active halt when irq enable set
// - Active halt clocks only oscillator and timebase
// - Active halt delay only on reset exit
// - Halt entry forces mask; pending irq wakes
// - Active halt never triggers watchdog reset
// - Full halt switches oscillator off
// - Full halt exit waits delay then vectors
// - Option decides watchdog reset on halt
// - Only listed sources end either halt
// - Timers, sci, voltage detector never end a halt
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
module psm_ctrl
    import psm_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 srst_i,
    input  wire logic                 ce_i,
    input  wire logic [3:0]           avs_address_i,
    input  wire logic                 avs_read_i,
    input  wire logic                 avs_write_i,
    input  wire logic [31:0]          avs_writedata_i,
    input  wire logic [3:0]           avs_byteenable_i,
    output logic      [31:0]          avs_readdata_o,
    output logic                      avs_waitrequest_o,
    input  wire logic                 wfi_instr_i,
    input  wire logic                 halt_instr_i,
    input  wire logic [psm_pkg::PSM_NSRC-1:0] irq_pend_i,
    input  wire logic [psm_pkg::PSM_NEXT-1:0] ext_irq_pin_i,
    input  wire logic                 reset_pin_i,
    input  wire logic [1:0]           irq_level_i,
    input  wire logic                 watchdog_active_i,
    output logic                      cpu_clk_en_o,
    output logic                      periph_clk_en_o,
    output logic                      osc_enable_o,
    output logic                      timebase_run_o,
    output logic                      mask_force_o,
    output logic      [1:0]           mask_value_o,
    output logic                      svc_push_o,
    output logic      [1:0]           svc_level_o,
    output logic                      resume_o,
    output logic                      resume_is_reset_o,
    output logic                      watchdog_reset_o
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [PSM_NEXT-1:0] ext_s;               // Filtered external lines
    logic                rst_s;               // Filtered reset request

    psm_sync3 #(.W(PSM_NEXT + 1)) u_sync (
        .clk_i  (clk_i),
        .srst_i (srst_i),
        .ce_i   (ce_i),
        .d_i    ({reset_pin_i, ext_irq_pin_i}),
        .q_o    ({rst_s, ext_s})
    );

    // Merge external lines into their source slots
    logic [PSM_NSRC-1:0] pend;
    always_comb begin
        pend = irq_pend_i;
        pend[PSM_EXT_LSB +: PSM_NEXT] = irq_pend_i[PSM_EXT_LSB +: PSM_NEXT]
                                      | ext_s;
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------------
    psm_ctrl_t   ctrl_q;                      // Control register
    psm_ctrl_t   ctrl_d;
    logic        ack_q;                       // Second cycle of access
    logic        ack_d;
    logic [31:0] rdata_q;                     // Read data holding
    logic [31:0] rdata_d;
    psm_state_t  st_q;                        // Mode state
    psm_state_t  st_d;
    logic        slow_act_q;                  // Slow in force
    logic        slow_act_d;
    logic [1:0]  div_sel_q;                   // Divider in force
    logic [1:0]  div_sel_d;

    // One wait state: data is prepared, then waitrequest drops
    always_comb begin
        ctrl_d  = ctrl_q;
        ack_d   = 1'b0;
        rdata_d = rdata_q;
        if ((avs_read_i || avs_write_i) && !ack_q) begin
            ack_d   = 1'b1;
            rdata_d = 32'h0000_0000;          // Unmapped reads as zero
            if (avs_read_i) begin
                unique case (avs_address_i)
                    PSM_CTRL_OFS:
                        rdata_d[5:0] = ctrl_q;
                    PSM_STATUS_OFS:
                        rdata_d[5:0] = {slow_act_q, div_sel_q, st_q};
                    default:
                        rdata_d = 32'h0000_0000;
                endcase
            end
        end
        // Write lands at the edge where waitrequest is low
        if (avs_write_i && ack_q && avs_byteenable_i[0] &&
            avs_address_i == PSM_CTRL_OFS) begin
            ctrl_d = avs_writedata_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl_q  <= PSM_CTRL_RST;
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else if (ce_i) begin
            ctrl_q  <= ctrl_d;
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
    assign avs_readdata_o    = rdata_q;

    // ------------------------------------------------------------------
    // Slow clock divider
    // ------------------------------------------------------------------
    logic [3:0] div_cnt_q;                    // Counts down to a tick
    logic [3:0] div_cnt_d;
    logic       tick;                         // One CPU cycle enable

    // Settings are sampled only at a tick so no period is ever cut short
    always_comb begin
        tick       = !slow_act_q || (div_cnt_q == 4'h0);
        div_cnt_d  = div_cnt_q;
        slow_act_d = slow_act_q;
        div_sel_d  = div_sel_q;
        if (osc_enable_o) begin
            if (tick) begin
                slow_act_d = ctrl_q.slow_enable;
                div_sel_d  = ctrl_q.slow_divider_select;
                // Reload of 1,3,7,15 gives divide by 2,4,8,16
                div_cnt_d  = ctrl_q.slow_enable ?
                    4'((5'h02 << ctrl_q.slow_divider_select) - 5'h01) :
                    4'h0;
            end else begin
                div_cnt_d = div_cnt_q - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            div_cnt_q  <= 4'h0;
            slow_act_q <= 1'b0;
            div_sel_q  <= 2'h0;
        end else if (ce_i) begin
            div_cnt_q  <= div_cnt_d;
            slow_act_q <= slow_act_d;
            div_sel_q  <= div_sel_d;
        end
    end

    // ------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------
    logic [12:0] cnt_q;                       // Oscillator settling count
    logic [12:0] cnt_d;
    logic [12:0] grd_q;                       // Guard after irq exit
    logic [12:0] grd_d;
    logic        rst_wake_q;                  // Settling caused by reset
    logic        rst_wake_d;
    logic        mforce_q, mforce_d;          // Mask force pulse
    logic        push_q, push_d;              // Status push pulse
    logic [1:0]  lvl_q, lvl_d;                // Service priority
    logic        res_q, res_d;                // Resume pulse
    logic        resr_q, resr_d;              // Resume by reset
    logic        wdr_q, wdr_d;                // Watchdog reset pulse
    logic [12:0] dly;                         // Selected wake delay

    always_comb begin
        dly        = ctrl_q.long_delay ? PSM_DLY_LONG : PSM_DLY_SHORT;
        st_d       = st_q;
        cnt_d      = cnt_q;
        grd_d      = (grd_q != 13'h0) ? grd_q - 13'h1 : grd_q;
        rst_wake_d = rst_wake_q;
        mforce_d   = 1'b0;
        push_d     = 1'b0;
        lvl_d      = lvl_q;
        res_d      = 1'b0;
        resr_d     = 1'b0;
        wdr_d      = 1'b0;
        unique case (st_q)
            PSM_RUN: begin
                if (rst_s) begin
                    res_d  = 1'b1;
                    resr_d = 1'b1;
                end else if (grd_q != 13'h0 && !ctrl_q.osc_irq_enable) begin
                    st_d = PSM_HREM;
                end else if (halt_instr_i) begin
                    if (ctrl_q.osc_irq_enable) begin
                        st_d     = PSM_AHALT;
                        mforce_d = 1'b1;
                    end else if (watchdog_active_i &&
                                 !ctrl_q.wdg_halt_opt) begin
                        wdr_d = 1'b1;
                    end else begin
                        st_d     = PSM_HALT;
                        mforce_d = 1'b1;
                    end
                end else if (wfi_instr_i) begin
                    st_d     = PSM_WAIT;
                    mforce_d = 1'b1;
                end
            end
            PSM_WAIT: begin
                // Any source or reset ends wait
                if (rst_s) begin
                    st_d   = PSM_RUN;
                    res_d  = 1'b1;
                    resr_d = 1'b1;
                end else if (|pend) begin
                    st_d   = PSM_RUN;
                    res_d  = 1'b1;
                    push_d = 1'b1;
                    lvl_d  = irq_level_i;
                end
            end
            PSM_AHALT: begin
                if (rst_s) begin
                    st_d       = PSM_STAB;
                    cnt_d      = dly;
                    rst_wake_d = 1'b1;
                end else if (|(pend & PSM_AHALT_WAKE)) begin
                    st_d   = PSM_RUN;
                    res_d  = 1'b1;
                    push_d = 1'b1;
                    lvl_d  = irq_level_i;
                    grd_d  = dly;
                end
            end
            PSM_HALT: begin
                if (rst_s || |(pend & PSM_HALT_WAKE)) begin
                    st_d       = PSM_STAB;
                    cnt_d      = dly;
                    rst_wake_d = rst_s;
                end
            end
            PSM_STAB: begin
                // Oscillator on, counting out the settling time
                if (cnt_q <= 13'h1) begin
                    st_d   = PSM_RUN;
                    res_d  = 1'b1;
                    resr_d = rst_wake_q;
                    push_d = !rst_wake_q;
                    lvl_d  = irq_level_i;
                    cnt_d  = 13'h0;
                end else begin
                    cnt_d = cnt_q - 13'h1;
                end
            end
            PSM_HREM: begin
                // Oscillator off for the rest of the guard period
                if (grd_q <= 13'h1) begin
                    st_d = PSM_RUN;
                end
            end
            default: begin
                st_d = PSM_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_q       <= PSM_RUN;
            cnt_q      <= 13'h0;
            grd_q      <= 13'h0;
            rst_wake_q <= 1'b0;
            mforce_q   <= 1'b0;
            push_q     <= 1'b0;
            lvl_q      <= 2'h0;
            res_q      <= 1'b0;
            resr_q     <= 1'b0;
            wdr_q      <= 1'b0;
        end else if (ce_i) begin
            st_q       <= st_d;
            cnt_q      <= cnt_d;
            grd_q      <= grd_d;
            rst_wake_q <= rst_wake_d;
            mforce_q   <= mforce_d;
            push_q     <= push_d;
            lvl_q      <= lvl_d;
            res_q      <= res_d;
            resr_q     <= resr_d;
            wdr_q      <= wdr_d;
        end
    end

    // ------------------------------------------------------------------
    // Clock gating and pulse outputs
    // ------------------------------------------------------------------
    // Oscillator off in full halt and in the guard tail after an active halt irq exit once the irq enable is cleared
    assign osc_enable_o    = !(st_q == PSM_HALT || st_q == PSM_HREM);
    assign timebase_run_o  = osc_enable_o;
    assign cpu_clk_en_o    = ce_i && tick && st_q == PSM_RUN;
    assign periph_clk_en_o = ce_i && tick &&
                             (st_q == PSM_RUN || st_q == PSM_WAIT);
    assign mask_force_o     = mforce_q;
    assign mask_value_o     = PSM_MASK_ALL;
    assign svc_push_o       = push_q;
    assign svc_level_o      = lvl_q;
    assign resume_o         = res_q;
    assign resume_is_reset_o = resr_q;
    assign watchdog_reset_o = wdr_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i || !ce_i);

    sequence s_halt_irq;
        halt_instr_i && st_q == PSM_RUN && !rst_s &&
        ctrl_q.osc_irq_enable && !(grd_q != 13'h0);
    endsequence

    a_wait_mask_force: assert property (
        st_q == PSM_RUN && wfi_instr_i && !rst_s && !halt_instr_i &&
        grd_q == 13'h0 |=> mforce_q && st_q == PSM_WAIT)
        else $error("wait entry did not force mask");
    a_ahalt_no_wdog: assert property (
        s_halt_irq |=> !wdr_q && st_q == PSM_AHALT && mforce_q)
        else $error("active halt entry wrong");
    a_halt_wdog_opt: assert property (
        st_q == PSM_RUN && halt_instr_i && !rst_s && grd_q == 13'h0 &&
        !ctrl_q.osc_irq_enable && watchdog_active_i &&
        !ctrl_q.wdg_halt_opt |=> wdr_q && st_q == PSM_RUN)
        else $error("watchdog halt reset missing");
    a_halt_osc_off: assert property (
        st_q == PSM_HALT |-> !osc_enable_o && !periph_clk_en_o)
        else $error("oscillator running in halt");
    a_ahalt_clocks: assert property (
        st_q == PSM_AHALT |-> osc_enable_o && timebase_run_o &&
        !periph_clk_en_o && !cpu_clk_en_o)
        else $error("clocks wrong in active halt");
    a_ahalt_irq_fast: assert property (
        st_q == PSM_AHALT && !rst_s && pend[0] |=> res_q && push_q &&
        st_q == PSM_RUN)
        else $error("active halt irq exit delayed");
    a_halt_no_timer: assert property (
        st_q == PSM_HALT && !rst_s && (pend & PSM_HALT_WAKE) == 10'h000
        |=> st_q == PSM_HALT)
        else $error("halt left on non-wake source");
    a_stab_delay: assert property (
        st_q == PSM_HALT && $past(st_q) == PSM_HALT ##1
        st_q == PSM_STAB |-> !res_q [*8])
        else $error("resume before settling");
    a_wait_irq_wake: assert property (
        st_q == PSM_WAIT && !rst_s && |pend |=> res_q && svc_push_o)
        else $error("wait irq exit missing");
    a_div_stable: assert property (
        !tick && osc_enable_o |=> $stable(div_sel_q) && $stable(slow_act_q))
        else $error("divider changed mid period");
endmodule

// >>> design/psm_sync3.sv
// Three-stage input synchroniser for pins, one lane per bit.
// Assumes inputs are asynchronous to clk_i; output follows a change once
// stages two and three agree.
`timescale 1ns/1ns
module psm_sync3 #(
    parameter int W = 1                       // Lane count
) (
    input  wire logic         clk_i,
    input  wire logic         srst_i,
    input  wire logic         ce_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    // ------------------------------------------------------------------
    // Per-lane chain
    // ------------------------------------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_lane
        logic [2:0] s_q;                      // Stage 0 read only by stage 1
        logic [2:0] s_d;
        logic       o_q;                      // Filtered level
        logic       o_d;

        // Next values; first stage only feeds the second
        always_comb begin
            s_d = {s_q[1:0], d_i[g]};
            o_d = (s_q[1] == s_q[2]) ? s_q[2] : o_q;
        end

        // Registers freeze with the clock enable
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                s_q <= 3'h0;
                o_q <= 1'b0;
            end else if (ce_i) begin
                s_q <= s_d;
                o_q <= o_d;
            end
        end

        assign q_o[g] = o_q;
    end
endmodule

// >>> inc/psm_pkg.sv
// Package for the power saving mode controller: register map, control
// field layout, wake masks, wake delay figures and the state encoding.
// Assumes a single 100 MHz master clock and a 32-bit Avalon-MM slave.
package psm_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] PSM_CTRL_OFS   = 4'h0;   // Control register
    localparam logic [3:0] PSM_STATUS_OFS = 4'h4;   // Status register

    // ------------------------------------------------------------------
    // Control field positions and reset value
    // ------------------------------------------------------------------
    localparam int PSM_DIV_LSB   = 0;               // Two-bit divider field
    localparam int PSM_SLOW_BIT  = 2;               // Slow enable
    localparam int PSM_OIE_BIT   = 3;               // Oscillator irq enable
    localparam int PSM_LONG_BIT  = 4;               // Long wake delay option
    localparam int PSM_WDGH_BIT  = 5;               // Watchdog halt option
    localparam logic [5:0] PSM_CTRL_RST = 6'h00;    // All off after reset

    // ------------------------------------------------------------------
    // Interrupt source indices and wake capability
    // ------------------------------------------------------------------
    localparam int PSM_NSRC      = 10;              // Timebase..voltage det.
    localparam int PSM_EXT_LSB   = 1;               // First external line
    localparam int PSM_NEXT      = 4;               // External lines
    // Bit 0 timebase, 1..4 external, 5 sync serial, 6..9 timers, sci, avd
    localparam logic [9:0] PSM_AHALT_WAKE = 10'h03F;
    localparam logic [9:0] PSM_HALT_WAKE  = 10'h03E;

    // ------------------------------------------------------------------
    // Interrupt mask forced on wait and halt entry
    // ------------------------------------------------------------------
    localparam logic [1:0] PSM_MASK_ALL = 2'h2;     // Binary 10

    // ------------------------------------------------------------------
    // Wake delay, in CPU cycles as printed
    // ------------------------------------------------------------------
    localparam int PSM_CLK_MHZ     = 100;           // Master clock rate
    localparam int PSM_DLY_SHORT_C = 256;           // Short delay, cycles
    localparam int PSM_DLY_LONG_C  = 4096;          // Long delay, cycles
    localparam int PSM_CPU_PER_MCLK = 1;            // Oscillator restarts
    localparam logic [12:0] PSM_DLY_SHORT =
        13'(PSM_DLY_SHORT_C * PSM_CPU_PER_MCLK);
    localparam logic [12:0] PSM_DLY_LONG  =
        13'(PSM_DLY_LONG_C * PSM_CPU_PER_MCLK);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       wdg_halt_opt;     // 0: halt with watchdog resets
        logic       long_delay;       // Wake delay select
        logic       osc_irq_enable;   // Halt picks active halt
        logic       slow_enable;      // Slow mode on
        logic [1:0] slow_divider_select;
    } psm_ctrl_t;

    typedef enum logic [2:0] {
        PSM_RUN   = 3'b000,           // CPU running
        PSM_WAIT  = 3'b001,           // CPU stopped, peripherals run
        PSM_AHALT = 3'b010,           // Only oscillator and timebase
        PSM_HALT  = 3'b011,           // Oscillator off
        PSM_STAB  = 3'b100,           // Oscillator settling
        PSM_HREM  = 3'b101            // Halted for rest of guard time
    } psm_state_t;

endpackage

// >>> tb/psm_cpu_model.sv
// CPU core stand-in: turns bench requests into instruction pulses.
// Assumes one request level per cycle from the bench, same clock.
`timescale 1ns/1ns
module psm_cpu_model (
    input  wire logic       clk_i,
    input  wire logic [1:0] req_i,
    output logic            wfi_o,
    output logic            halt_o
);
    // Registered: a core retires at most one instruction a cycle
    always_ff @(posedge clk_i) begin
        wfi_o  <= req_i[0];
        halt_o <= req_i[1];
    end
endmodule

// >>> tb/tb_psm_ctrl.sv
// Bench for the power mode controller: slow clock, wait, both halts.
// Assumes one 100 MHz clock; pulses are sampled on the falling edge.
`timescale 1ns/1ns
module tb_psm_ctrl;
    import psm_pkg::*;
    logic        clk_i = 0, srst_i = 1, rd = 0, wr = 0, wd = 0, rp = 0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, r, seed = 32'h4012;
    logic [9:0]  irq = 10'h000;
    logic [1:0]  lvl = 2'h0, req = 2'h0, lvl_q, mv, sl;
    logic        wait_for_irq_instr, hlt, wq, cpu, per, osc, mf, push, res, wrst;
    logic        tbr, rr, lrr;   // Timebase run, reset flag, last flag
    int          errors = 0, n_compared = 0, n_res = 0, n_mf = 0;
    int          n_wd = 0, c, p, n;
    always #5 clk_i = ~clk_i;
    psm_cpu_model i_psm_cpu_model (.clk_i(clk_i), .req_i(req),
        .wfi_o(wait_for_irq_instr), .halt_o(hlt));
    psm_ctrl i_psm_ctrl (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
        .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
        .avs_writedata_i(wdat), .avs_byteenable_i(4'hF),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
        .wfi_instr_i(wait_for_irq_instr), .halt_instr_i(hlt), .irq_pend_i(irq),
        .ext_irq_pin_i(4'h0), .reset_pin_i(rp), .irq_level_i(lvl),
        .watchdog_active_i(wd), .cpu_clk_en_o(cpu),
        .periph_clk_en_o(per), .osc_enable_o(osc), .timebase_run_o(tbr),
        .mask_force_o(mf), .mask_value_o(mv), .svc_push_o(push),
        .svc_level_o(sl), .resume_o(res), .resume_is_reset_o(rr),
        .watchdog_reset_o(wrst));
    // Sticky counts of one-cycle pulses, read away from the edge
    always @(negedge clk_i) begin
        if (mf === 1'b1 && mv === 2'b10) n_mf++;
        // Flag kept here, not in the waiter, to avoid a same-edge race
        if (res === 1'b1) begin
            n_res++;
            lrr = rr;
        end
        if (push === 1'b1) lvl_q = sl;
        if (wrst === 1'b1) n_wd++;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task print_verdict();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(posedge clk_i);
    endtask
    // Request held until waitrequest is sampled low at a rising edge
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_i);
        rd <= !w; wr <= w; adr <= a; wdat <= d;
        do begin @(posedge clk_i); k++; end while (wq !== 1'b0 && k < 20);
        if (k >= 20) begin chk(1'b0, "bus hang"); print_verdict(); end
        // Same edge: write lands, read data taken, then release
        r = rdat;
        rd <= 0; wr <= 0;
    endtask
    // Clock enable pulses over 32 cycles; a whole number of ticks
    task cnt();
        c = 0;
        p = 0;
        repeat (32) begin @(negedge clk_i); c += cpu; p += per; end
    endtask
    task ins(input logic [1:0] b);
        req <= b;
        @(posedge clk_i);
        req <= 2'h0;
        cyc(3);
    endtask
    // Raise sources, count cycles to the resume pulse, then drop them
    task wake(input logic [9:0] m, input int lim);
        int k;
        k = n_res;
        n = 0;
        irq <= m;
        while (n_res == k && n < lim) begin @(negedge clk_i); n++; end
        if (n >= lim) begin chk(1'b0, "no wake"); print_verdict(); end
        @(posedge clk_i);
        irq <= 10'h000;
    endtask
    initial begin
        cyc(10);
        srst_i <= 0;
        bus(0, PSM_CTRL_OFS, 0); chk(r === 0, "ctrl reset");
        bus(0, PSM_STATUS_OFS, 0); chk(r === 0, "status reset");
        bus(0, 4'h8, 0); chk(r === 0, "unmapped");
        for (int d = 0; d < 4; d++) begin
            bus(1, PSM_CTRL_OFS, 32'h4 | d);
            cyc(20);
            cnt(); chk(c == (16 >> d), "slow rate");
            bus(0, PSM_STATUS_OFS, 0);
            chk(r[5:0] === {1'b1, 2'(d), 3'h0}, "slow st");
        end
        bus(1, PSM_CTRL_OFS, 32'h5);
        cyc(20);
        n = n_mf;
        ins(2'h1);
        cnt(); chk(c == 0 && p == 8, "slow wait");
        chk(n_mf == n + 1, "wait mask");
        bus(0, PSM_STATUS_OFS, 0); chk(r[2:0] === 3'h1, "wait");
        lvl <= 2'(rnd());
        wake(10'h001 << (1 + rnd() % 4), 8);
        chk(lvl_q === lvl, "wake level");
        bus(1, PSM_CTRL_OFS, 0);
        n = n_mf;
        ins(2'h2);
        bus(0, PSM_STATUS_OFS, 0);
        chk(r[2:0] === 3'h3 && osc === 1'b0, "halt");
        chk(tbr === 1'b0, "timebase off");
        chk(n_mf == n + 1, "halt mask");
        n = n_res;
        irq <= 10'h3C1;
        cyc(30); chk(n_res == n, "halt no wake");
        wake(10'h3C2, 300); chk(n >= 256 && n < 270, "delay");
        chk(lrr === 1'b0, "irq vector");
        wd <= 1;
        bus(1, PSM_CTRL_OFS, 32'h8);
        ins(2'h2);
        bus(0, PSM_STATUS_OFS, 0);
        chk(r[2:0] === 3'h2 && osc === 1'b1, "ahalt");
        chk(tbr === 1'b1, "timebase on");
        wake(10'h001, 300); chk(n < 8, "ahalt exit");
        cyc(300); // Enable kept set through the guard
        chk(n_wd == 0, "ahalt wdg");
        // Second active halt, enable cleared inside the guard time
        ins(2'h2);
        wake(10'h001, 300); chk(n < 8, "ahalt exit 2");
        bus(1, PSM_CTRL_OFS, 0);
        bus(0, PSM_STATUS_OFS, 0);
        chk(r[2:0] === 3'h5 && osc === 1'b0, "guard halt");
        cyc(300);
        bus(1, PSM_CTRL_OFS, 0);
        ins(2'h2);
        bus(0, PSM_STATUS_OFS, 0);
        chk(n_wd == 1 && r[2:0] === 3'h0, "halt wdg");
        // Reset pin ends active halt after the long settling delay
        bus(1, PSM_CTRL_OFS, 32'h18);
        ins(2'h2);
        rp <= 1;
        wake(10'h000, 5000);
        chk(n >= 4096 && n < 4110 && lrr === 1'b1, "reset exit");
        rp <= 0;
        print_verdict();
    end
endmodule
